// *** slc_params.svh ***
// constants for the sequence launch control block
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH
`define SLC_SEL_W 6
`define SLC_BOOT_SEQ 6'h00
`define SLC_POL_RISE 1'b0
`define SLC_POL_FALL 1'b1
`define SLC_CMD_NONE 2'h0
`define SLC_CMD_RUN 2'h1
`define SLC_CMD_ABORT 2'h2
`define SLC_A_CTRL 4'h0
`define SLC_A_CMD 4'h4
`define SLC_A_STAT 4'h8
`define SLC_A_LAST 4'hc
`define SLC_CTRL_POL 0
`define SLC_CTRL_MASK_LO 8
`define SLC_CMD_GO 16
`define SLC_CMD_ABT 17
`define SLC_CTRL_RST 32'h0000_0000
`define SLC_EDGE_WARM 2'h3
`endif

// *** slc_pkg.sv ***
// types shared by the sequence launch control block
package slc_pkg;
   typedef enum logic [1:0] {SLC_SRC_BOOT, SLC_SRC_TERM, SLC_SRC_IO} slc_src_t;
   typedef enum {SLC_ST_BOOT, SLC_ST_IDLE, SLC_ST_RUN} slc_state_t;
endpackage

// *** slc_sync.sv ***
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module slc_sync #(
   parameter int W = 7
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   // first stage feeds only the second
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
      end
   end
   assign q_o = s2_reg;
endmodule

// *** slc_top.sv ***
// sequence launch control: boot, terminal and i/o launch of stored sequences
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "slc_params.svh"
module slc_top (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [`SLC_SEL_W-1:0] seq_select_i,
   input wire logic start_i,
   input wire logic abort_i,
   output logic seq_launch_o,
   output logic [`SLC_SEL_W-1:0] seq_number_o,
   output slc_pkg::slc_src_t seq_source_o,
   output logic seq_running_o,
   output logic seq_abort_o
);
   import slc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic rst_a_reg;
   logic rst_n_reg;
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_a_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_a_reg <= 1'b1;
         rst_n_reg <= rst_a_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronise select and start
   logic [`SLC_SEL_W:0] sync_q;
   slc_sync #(.W(`SLC_SEL_W + 1)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_reg),
      .d_i({start_i, seq_select_i}),
      .q_o(sync_q)
   );
   logic start_s;
   logic start_d_reg;
   logic abort_s_reg;
   logic [1:0] warm_reg, warm_next;
   logic edge_ok;
   assign start_s = sync_q[`SLC_SEL_W];
   // edges count only once the sync chain holds pin levels: a start pin
   // held high through reset would otherwise fake a rising edge
   always_comb begin
      warm_next = warm_reg;
      if (warm_reg != `SLC_EDGE_WARM) begin
         warm_next = warm_reg + 2'h1;
      end
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         start_d_reg <= 1'b0;
         abort_s_reg <= 1'b0;
         warm_reg <= 2'h0;
      end else begin
         start_d_reg <= start_s;
         abort_s_reg <= abort_i;
         warm_reg <= warm_next;
      end
   end
   assign edge_ok = (warm_reg == `SLC_EDGE_WARM);

   // binary number, masked bits read zero
   function automatic logic [`SLC_SEL_W-1:0] sel_num(
      input logic [`SLC_SEL_W-1:0] raw,
      input logic [`SLC_SEL_W-1:0] msk
   );
      sel_num = raw & ~msk;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers: ctrl holds polarity and the hold assignment mask
   logic pol_reg, pol_next;
   logic [`SLC_SEL_W-1:0] mask_reg, mask_next;
   logic [`SLC_SEL_W-1:0] cmd_num_reg, cmd_num_next;
   logic cmd_go_reg, cmd_go_next;
   logic cmd_abt_reg, cmd_abt_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wait_reg, wait_next;
   logic req;
   assign req = avs_read | avs_write;

   always_comb begin
      pol_next = pol_reg;
      mask_next = mask_reg;
      cmd_num_next = cmd_num_reg;
      cmd_go_next = 1'b0;
      cmd_abt_next = 1'b0;
      rdata_next = rdata_reg;
      // one wait cycle per access keeps read data registered
      wait_next = 1'b1;
      if (req && wait_reg) begin
         // first edge: read data registered, waitrequest drops next cycle
         wait_next = 1'b0;
         if (avs_read) begin
            case (avs_address)
               `SLC_A_CTRL: rdata_next = {16'h0000, 2'h0, mask_reg, 7'h00, pol_reg};
               `SLC_A_CMD: rdata_next = {26'h0, cmd_num_reg};
               `SLC_A_STAT: rdata_next = {22'h0, seq_source_o, seq_running_o,
                                          1'b0, seq_number_o};
               `SLC_A_LAST: rdata_next = {26'h0, sel_num(sync_q[`SLC_SEL_W-1:0], mask_reg)};
               default: rdata_next = 32'h0000_0000;
            endcase
         end
      end else if (avs_write) begin
         // write lands on the edge that sees waitrequest low
         case (avs_address)
            `SLC_A_CTRL: begin
               pol_next = avs_writedata[`SLC_CTRL_POL];
               mask_next = avs_writedata[`SLC_CTRL_MASK_LO +: `SLC_SEL_W];
            end
            `SLC_A_CMD: begin
               cmd_num_next = avs_writedata[`SLC_SEL_W-1:0];
               cmd_go_next = avs_writedata[`SLC_CMD_GO];
               cmd_abt_next = avs_writedata[`SLC_CMD_ABT];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         pol_reg <= `SLC_POL_RISE;
         mask_reg <= '0;
         cmd_num_reg <= '0;
         cmd_go_reg <= 1'b0;
         cmd_abt_reg <= 1'b0;
         rdata_reg <= `SLC_CTRL_RST;
         wait_reg <= 1'b1;
      end else begin
         pol_reg <= pol_next;
         mask_reg <= mask_next;
         cmd_num_reg <= cmd_num_next;
         cmd_go_reg <= cmd_go_next;
         cmd_abt_reg <= cmd_abt_next;
         rdata_reg <= rdata_next;
         wait_reg <= wait_next;
      end
   end
   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;

   ////////////////////////////////////////////////////////////////////////////
   logic rise, fall, io_go, io_abt;
   assign rise = start_s & ~start_d_reg & edge_ok;
   assign fall = ~start_s & start_d_reg & edge_ok;
   assign io_go = (pol_reg == `SLC_POL_RISE) ? rise : fall;
   assign io_abt = (pol_reg == `SLC_POL_FALL) ? rise : 1'b0;

   slc_state_t st_reg, st_next;
   logic launch_next, abort_next, running_next;
   logic [`SLC_SEL_W-1:0] num_reg, num_next;
   slc_src_t src_reg, src_next;

   always_comb begin
      st_next = st_reg;
      num_next = num_reg;
      src_next = src_reg;
      launch_next = 1'b0;
      abort_next = 1'b0;
      case (st_reg)
         // boot sequence without any start input
         SLC_ST_BOOT: begin
            st_next = SLC_ST_RUN;
            num_next = `SLC_BOOT_SEQ;
            src_next = SLC_SRC_BOOT;
            launch_next = 1'b1;
         end
         SLC_ST_IDLE, SLC_ST_RUN: begin
            // abort input or terminal abort bit ends a run; at polarity 1 the rising edge too
            if ((abort_s_reg || io_abt || cmd_abt_reg) && st_reg == SLC_ST_RUN) begin
               st_next = SLC_ST_IDLE;
               abort_next = 1'b1;
            end else if (io_go) begin
               st_next = SLC_ST_RUN;
               num_next = sel_num(sync_q[`SLC_SEL_W-1:0], mask_reg);
               src_next = SLC_SRC_IO;
               launch_next = 1'b1;
            end else if (cmd_go_reg) begin
               st_next = SLC_ST_RUN;
               num_next = cmd_num_reg;
               src_next = SLC_SRC_TERM;
               launch_next = 1'b1;
            end
         end
         default: st_next = SLC_ST_IDLE;
      endcase
      running_next = (st_next == SLC_ST_RUN);
   end

   logic launch_reg, abort_reg, running_reg;
   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         st_reg <= SLC_ST_BOOT;
         num_reg <= '0;
         src_reg <= SLC_SRC_BOOT;
         launch_reg <= 1'b0;
         abort_reg <= 1'b0;
         running_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         num_reg <= num_next;
         src_reg <= src_next;
         launch_reg <= launch_next;
         abort_reg <= abort_next;
         running_reg <= running_next;
      end
   end
   assign seq_launch_o = launch_reg;
   assign seq_abort_o = abort_reg;
   assign seq_number_o = num_reg;
   assign seq_source_o = src_reg;
   assign seq_running_o = running_reg;

   ////////////////////////////////////////////////////////////////////////////
   // boot launch right after reset
   AST_BOOT: assert property (@(posedge ref_clk_i)
      $rose(rst_n_reg) |-> ##1 (seq_launch_o && seq_number_o == `SLC_BOOT_SEQ &&
      seq_source_o == SLC_SRC_BOOT))
      else $error("boot sequence not launched");
   // release of start never aborts at polarity 0
   AST_NO_FALL_ABORT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
      (!pol_reg && fall && !abort_s_reg && !cmd_abt_reg) |=> !seq_abort_o)
      else $error("falling start aborted at polarity 0");
   // rising start aborts at polarity 1
   AST_RISE_ABORT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
      (pol_reg && rise && seq_running_o) |=> seq_abort_o && !seq_running_o)
      else $error("rising start did not abort");
   // launched io number equals masked select
   AST_IO_NUM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
      (seq_launch_o && seq_source_o == SLC_SRC_IO) |->
      seq_number_o == ($past(sync_q[`SLC_SEL_W-1:0]) & ~$past(mask_reg)))
      else $error("io number wrong");
   // masked bits are zero in number
   AST_MASK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
      (seq_launch_o && seq_source_o == SLC_SRC_IO) |->
      (seq_number_o & $past(mask_reg)) == 6'h00)
      else $error("masked select bit leaked");
   AST_CMD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
      (cmd_go_reg && !io_go && !abort_s_reg && !cmd_abt_reg && !io_abt &&
      st_reg != SLC_ST_BOOT) |=> seq_launch_o && seq_number_o == $past(cmd_num_reg))
      else $error("run command not launched");
   AST_ABORT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
      (abort_s_reg && seq_running_o && st_reg == SLC_ST_RUN) |=> !seq_running_o)
      else $error("abort input ignored");
   // active edge launches on the next cycle
   AST_LAT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
      (io_go && !abort_s_reg && !cmd_abt_reg && !io_abt) |=> seq_launch_o)
      else $error("io launch missing");
endmodule

// *** slc_ctl_model.sv ***
// behavioural external controller on the select, start and abort pins
`timescale 1ns/1ps
`include "slc_params.svh"
module slc_ctl_model (
   input wire logic ref_clk_i,
   output logic [`SLC_SEL_W-1:0] sel_o,
   output logic start_o,
   output logic abort_o
);
   initial begin
      sel_o <= 6'h00;
      start_o <= 1'b0;
      abort_o <= 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // select held ahead of start
   task automatic set_sel(input logic [`SLC_SEL_W-1:0] v);
      sel_o <= v;
      repeat (2) @(posedge ref_clk_i);
   endtask
   task automatic set_start(input logic v);
      start_o <= v;
      @(posedge ref_clk_i);
   endtask
   task automatic pulse_abort;
      abort_o <= 1'b1;
      @(posedge ref_clk_i);
      abort_o <= 1'b0;
   endtask
endmodule

// *** slc_top_test.sv ***
// self-checking bench for the sequence launch control block
`timescale 1ns/1ps
`include "slc_params.svh"
module slc_top_test;
   import slc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic nrst_i;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [`SLC_SEL_W-1:0] sel;
   logic [`SLC_SEL_W-1:0] number;
   logic start, abort, launch, running, abrt;
   slc_src_t source;
   logic [31:0] rd;
   int err_total = 0;
   int cmp_count = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   slc_top u_slc_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .seq_select_i(sel),
      .start_i(start), .abort_i(abort), .seq_launch_o(launch), .seq_number_o(number),
      .seq_source_o(source), .seq_running_o(running), .seq_abort_o(abrt));
   slc_ctl_model u_slc_ctl_model (.ref_clk_i(ref_clk_i), .sel_o(sel), .start_o(start),
      .abort_o(abort));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bus request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      chk(32'(n < 50), 32'h1);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   // bounded wait for a launch or an abort pulse
   task automatic wait_ev(input logic ab);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while ((ab ? abrt : launch) !== 1'b1 && n < 12);
      chk(32'(n < 12), 32'h1);
   endtask
   task automatic see(input logic [5:0] num, input slc_src_t src);
      wait_ev(1'b0);
      chk(32'(number), 32'(num));
      chk(32'(source), 32'(src));
      chk(32'(running), 32'h1);
   endtask
   task automatic stop;
      wait_ev(1'b1);
      @(posedge ref_clk_i);
      chk(32'(running), 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_io;
      logic [5:0] tbl [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h03, 6'h3f};
      int cnt;
      foreach (tbl[i]) begin
         u_slc_ctl_model.set_sel(tbl[i]);
         u_slc_ctl_model.set_start(1'b1);
         see(tbl[i], SLC_SRC_IO);
         u_slc_ctl_model.set_start(1'b0);
         cnt = 0;
         repeat (8) begin
            @(posedge ref_clk_i);
            cnt += int'(launch === 1'b1);
         end
         chk(32'(cnt), 32'h0);
         chk(32'(running), 32'h1);
      end
      u_slc_ctl_model.set_sel(6'h00);
      chk(32'(number), 32'h3f);
      u_slc_ctl_model.pulse_abort();
      stop();
   endtask
   task automatic t_term;
      bus(1'b1, `SLC_A_CMD, 32'h0001_002a);
      see(6'h2a, SLC_SRC_TERM);
      bus(1'b0, `SLC_A_STAT, 32'h0);
      chk(rd, 32'h0000_01aa);
      bus(1'b0, `SLC_A_CMD, 32'h0);
      chk(rd, 32'h0000_002a);
      // unaligned offset is unmapped
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      // terminal abort bit ends the run without any pin activity
      bus(1'b1, `SLC_A_CMD, 32'h0002_0000);
      stop();
   endtask
   task automatic t_mask;
      bus(1'b1, `SLC_A_CTRL, 32'h0000_2000);
      bus(1'b0, `SLC_A_CTRL, 32'h0);
      chk(rd, 32'h0000_2000);
      u_slc_ctl_model.set_sel(6'h3f);
      bus(1'b0, `SLC_A_LAST, 32'h0);
      chk(rd, 32'h0000_001f);
      u_slc_ctl_model.set_start(1'b1);
      see(6'h1f, SLC_SRC_IO);
      u_slc_ctl_model.set_start(1'b0);
      u_slc_ctl_model.pulse_abort();
      stop();
   endtask
   task automatic t_pol1;
      bus(1'b1, `SLC_A_CTRL, 32'h0000_0001);
      u_slc_ctl_model.set_start(1'b1);
      repeat (6) @(posedge ref_clk_i);
      u_slc_ctl_model.set_sel(6'h15);
      u_slc_ctl_model.set_start(1'b0);
      see(6'h15, SLC_SRC_IO);
      u_slc_ctl_model.set_start(1'b1);
      stop();
   endtask
   // reset while idle with start held high: only the boot launch may follow
   task automatic t_reset;
      int cnt;
      cnt = 0;
      nrst_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      see(`SLC_BOOT_SEQ, SLC_SRC_BOOT);
      repeat (10) begin
         @(posedge ref_clk_i);
         cnt += int'(launch === 1'b1);
      end
      chk(32'(cnt), 32'h0);
      bus(1'b0, `SLC_A_CTRL, 32'h0);
      chk(rd, `SLC_CTRL_RST);
      u_slc_ctl_model.set_start(1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // generous span: the whole sequence needs a few hundred cycles
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      err_total++;
      final_report();
   end
   initial begin
      nrst_i <= 1'b0;
      avs_address <= 4'h0;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h0000_0000;
      repeat (12) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      see(`SLC_BOOT_SEQ, SLC_SRC_BOOT);
      t_io();
      t_term();
      t_mask();
      t_pol1();
      t_reset();
      final_report();
   end
endmodule
